// file: sim/rspo_load.sv
`default_nettype none
module rspo_load
(
  input  wire logic drive,
  output var  int   pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pulses = 0;
  // ground-referenced load: energised only while the pin is high
  always @(posedge drive)
    pulses++;
endmodule
`default_nettype wire

// file: sim/rspo_monitor.sv
`include "rspo_map.vh"
`default_nettype none
module rspo_monitor
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        speed_pulse_pin,
  input wire logic [7:0]  vehicle_speed,
  input wire logic        control_unit_speed_fault,
  input wire logic        body_module_speed_fault,
  input wire logic        road_speed_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] a, th;
  logic       w, en, inv, rs;
  wire        fl = control_unit_speed_fault | body_module_speed_fault;
  wire        sw = ce && en && th != 0 && !fl;
  wire        fq = ce && en && th == 0 && !fl;
  // shadow of the written config, threshold clamped to its range
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {w, a, th, en, inv, rs} <= '0;
    else
    begin
      w <= hsel && hready && htrans[1] && hwrite;
      a <= haddr[7:0];
      if (w && a == `RSPO_THRESH_OFS)
        th <= (hwdata > {24'h00_0000, `RSPO_THRESH_MAX}) ? `RSPO_THRESH_MAX : hwdata[7:0];
      if (w && a == `RSPO_CTRL_OFS)
        {rs, inv, en} <= hwdata[2:0];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence fq_rise;
    $rose(road_speed_output) && fq;
  endsequence
  sequence hi6;
    road_speed_output [*6] ##1 !road_speed_output;
  endsequence
  // level needs two edges to follow speed, so only settled inputs count
  sequence sw_steady;
    sw && vehicle_speed != th && $stable(vehicle_speed) && $stable(th) && $stable(inv);
  endsequence
  chk_off_low: assert property (!en [*2] |-> !road_speed_output)
    else $error("output high while disabled");
  chk_cu_fault: assert property (control_unit_speed_fault [*4] |-> !road_speed_output)
    else $error("output high under unit fault");
  chk_bm_fault: assert property (body_module_speed_fault [*4] |-> !road_speed_output)
    else $error("output high under body fault");
  chk_slow_low: assert property ((fq && vehicle_speed < `RSPO_SLOW_KMH) [*4] |-> !road_speed_output)
    else $error("pulse below lower speed");
  chk_sw_level: assert property (sw_steady [*4]
    |-> road_speed_output == ((vehicle_speed > th) ^ inv)) else $error("wrong switched level");
  chk_eq_hold: assert property ((sw && vehicle_speed == th) [*4] |-> $stable(road_speed_output))
    else $error("level moved at threshold");
  chk_pulse_len: assert property (fq_rise |-> hi6)
    else $error("wrong pulse high time");
  chk_pulse_src: assert property ((fq_rise ##0 !rs) |-> $past(speed_pulse_pin, 4))
    else $error("pulse without sensor pulse");
endmodule
bind rspo_top rspo_monitor CHK (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .speed_pulse_pin, .vehicle_speed, .control_unit_speed_fault, .body_module_speed_fault, .road_speed_output);
`default_nettype wire

// file: sim/testbench.sv
`include "rspo_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, speed_pulse_pin;
  logic        control_unit_speed_fault, body_module_speed_fault;
  logic        ce;
  logic [13:0] engine_rpm;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [7:0]  vehicle_speed;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, road_speed_output;
  int          failures, compares, ld_pulses;
  rspo_top DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .speed_pulse_pin, .vehicle_speed, .engine_rpm,
    .control_unit_speed_fault, .body_module_speed_fault, .road_speed_output);
  rspo_load LOAD (.drive(road_speed_output), .pulses(ld_pulses));
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++n > 50)
      begin
        failures++;
        summarize;
      end
      @(posedge hclk);
    end
  endtask
  // hsel stays up between transfers so no signal is driven twice in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rv;
    bus(1'b1, a, d, rv);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rv;
    bus(1'b0, a, 32'h0000_0000, rv);
    check("register", e, rv);
    check("response", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask
  task automatic out_is(input int n, input logic e);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
    check("road speed output", e, road_speed_output);
    @(posedge hclk);
  endtask
  task automatic sense(input int n);
    repeat (n)
    begin
      speed_pulse_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      speed_pulse_pin <= 1'b0;
      repeat (16) @(posedge hclk);
    end
  endtask
  task automatic t_regs;
    rd(`RSPO_CTRL_OFS, 32'h0000_0000);
    rd(`RSPO_THRESH_OFS, 32'h0000_0000);
    rd(`RSPO_FACTOR_OFS, 32'h0000_0011);
    rd(8'h20, 32'h0000_0000);
    rd(`RSPO_STATUS_OFS, 32'h0000_0008);
    rd(`RSPO_HIGHTIME_OFS, {16'h0000, `RSPO_HIGH_CYC});
    wr(`RSPO_THRESH_OFS, 32'h0000_00C8);
    rd(`RSPO_THRESH_OFS, 32'h0000_008C);
    wr(`RSPO_FACTOR_OFS, 32'h0000_0001);
    rd(`RSPO_FACTOR_OFS, 32'h0000_0002);
    wr(`RSPO_FACTOR_OFS, 32'h0000_0064);
    rd(`RSPO_FACTOR_OFS, 32'h0000_0048);
    out_is(0, 1'b0);
  endtask
  task automatic t_freq;
    int base;
    wr(`RSPO_THRESH_OFS, 32'h0000_0000);
    wr(`RSPO_HIGHTIME_OFS, 32'h0000_0006);
    wr(`RSPO_CTRL_OFS, 32'h0000_0001);
    vehicle_speed <= 8'h32;
    base = ld_pulses;
    sense(4);
    check("pulse count", base + 4, ld_pulses);
    vehicle_speed <= 8'h02;
    sense(2);
    check("slow pulse count", base + 4, ld_pulses);
    vehicle_speed <= 8'h32;
    control_unit_speed_fault <= 1'b1;
    sense(2);
    check("unit fault pulse count", base + 4, ld_pulses);
    control_unit_speed_fault <= 1'b0;
    body_module_speed_fault <= 1'b1;
    sense(2);
    check("body fault pulse count", base + 4, ld_pulses);
    body_module_speed_fault <= 1'b0;
  endtask
  // full-scale rpm at factor 72: wraps land 2120 and 4239 cycles in, the third after 5000
  task automatic t_rpm;
    int base;
    wr(`RSPO_CTRL_OFS, 32'h0000_0005);
    base = ld_pulses;
    engine_rpm <= 14'h3FFF;
    repeat (5000) @(posedge hclk);
    engine_rpm <= 14'h0000;
    repeat (8) @(posedge hclk);
    check("rpm pulse count", base + 2, ld_pulses);
  endtask
  task automatic t_switch;
    logic [7:0] sp [6] = '{8'h50, 8'h3C, 8'h28, 8'h3C, 8'h50, 8'h28};
    logic [5:0] ex = 6'b10_0011;
    wr(`RSPO_THRESH_OFS, 32'h0000_003C);
    for (int i = 0; i < 6; i++)
    begin
      wr(`RSPO_CTRL_OFS, {30'h0000_0000, i > 3, 1'b1});
      vehicle_speed <= sp[i];
      out_is(3, ex[i]);
    end
    // low enable freezes the level although speed crosses the threshold
    ce <= 1'b0;
    vehicle_speed <= 8'h50;
    out_is(3, 1'b1);
    ce <= 1'b1;
    out_is(3, 1'b0);
    wr(`RSPO_CTRL_OFS, 32'h0000_0000);
    out_is(1, 1'b0);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, speed_pulse_pin, control_unit_speed_fault, body_module_speed_fault} = '0;
    {haddr, hwdata, htrans, vehicle_speed} = '0;
    {ce, engine_rpm} = {1'b1, 14'h0000};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_freq;
    t_rpm;
    t_switch;
    summarize;
  end
endmodule
`default_nettype wire

// file: src/rspo_map.vh
`ifndef RSPO_MAP_VH
`define RSPO_MAP_VH
// register byte offsets
`define RSPO_CTRL_OFS        8'h00
`define RSPO_THRESH_OFS      8'h04
`define RSPO_FACTOR_OFS      8'h08
`define RSPO_STATUS_OFS      8'h0C
`define RSPO_HIGHTIME_OFS    8'h10
// ctrl fields
`define RSPO_CTRL_EN_BIT     0
`define RSPO_CTRL_INV_BIT    1
`define RSPO_CTRL_RPM_BIT    2
// status fields
`define RSPO_ST_OUT_BIT      0
`define RSPO_ST_MODE_BIT     1
`define RSPO_ST_FAULT_BIT    2
`define RSPO_ST_SLOW_BIT     3
// reset values, limits and constants
`define RSPO_CTRL_RST        32'h0000_0000
`define RSPO_THRESH_RST      8'h00
`define RSPO_FACTOR_RST      7'h11
`define RSPO_FACTOR_MIN      7'h02
`define RSPO_FACTOR_MAX      7'h48
`define RSPO_THRESH_MAX      8'h8C
`define RSPO_SLOW_KMH        8'h03
`define RSPO_PULSES_PER_REV  16
// timing
`define RSPO_CLK_HZ          25000000
`define RSPO_HIGH_TIME_US    500
// 500 us at 25 MHz, kept at the counter width
`define RSPO_HIGH_CYC        16'h30D4
// accumulator wrap of 100 times the clock rate
`define RSPO_RPM_WRAP        32'h9502_F900
`endif

// file: src/rspo_pulse_gen.v
`default_nettype none
// one fixed-length high pulse per trigger; low time is whatever the trigger spacing leaves
module rspo_pulse_gen #(
  parameter CW = 16
)
(
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          ce,
  input  wire          trig,
  input  wire [CW-1:0] high_cyc,
  output reg           pulse
);
  reg [CW-1:0] cnt;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt   <= {CW{1'b0}};
      pulse <= 1'b0;
    end
    else if (ce)
    begin
      if (trig && !pulse)
      begin
        cnt   <= high_cyc;
        pulse <= (high_cyc != {CW{1'b0}});
      end
      else if (cnt > {{(CW-1){1'b0}}, 1'b1})
        cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
      else
      begin
        cnt   <= {CW{1'b0}};
        pulse <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/rspo_sync.v
`default_nettype none
module rspo_sync
(
  input  wire hclk,
  input  wire hresetn,
  input  wire ce,
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// file: src/rspo_top.v
// Notes on behaviour
// - output stays low unless enable bit set; enable resets to off.
// - any speed fault from control unit or body module forces output low.
// - threshold zero selects frequency mode, nonzero selects switched mode; range 0..140.
// - frequency mode gives one output pulse per sensor pulse (16 per revolution).
// - rpm source pulse rate is rpm times factor over 100; factor 2..72, default 17.
// - pulse high time is fixed; only low time varies.
// - frequency mode holds output low below 3 km/h.
// - switched mode, not inverted: high above threshold, low below.
// - switched mode, inverted: low above threshold, high below; invert resets off.
// - output is active high; load referenced to ground.
`include "rspo_map.vh"
`default_nettype none
module rspo_top #(
  parameter CW       = 16,
  parameter RPM_ACCW = 32
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        speed_pulse_pin,
  input  wire [7:0]  vehicle_speed,
  input  wire [13:0] engine_rpm,
  input  wire        control_unit_speed_fault,
  input  wire        body_module_speed_fault,
  output reg         road_speed_output
);
  localparam [CW-1:0] HIGH_DEF = `RSPO_HIGH_CYC;
  reg          speed_output_enable;
  reg          switch_invert;
  reg          rpm_source;
  reg [7:0]    switch_speed_threshold;
  reg [6:0]    rpm_frequency_factor;
  reg [CW-1:0] pulse_high_time;
  reg          sw_level;
  reg          wr_pend;
  reg [7:0]    wr_addr;
  reg [RPM_ACCW-1:0] rpm_acc;
  reg          rpm_tick;
  wire         vss_sync;
  wire         fault_cu;
  wire         fault_bm;
  reg          vss_d;
  wire         vss_rise;
  wire         freq_pulse;
  wire         freq_mode;
  wire         faulted;
  wire         too_slow;
  wire         trig;
  reg          next_out;
  reg [31:0]   rd_mux;
  wire         acc_ok;
  wire [6:0]   wfac;
  wire [7:0]   wthr;
  // step rpm*factor per clock, one wrap per pulse: rpm*factor/100 Hz
  localparam [RPM_ACCW-1:0] RPM_WRAP = `RSPO_RPM_WRAP;
  // widened first: a self-sized product would keep only 14 bits
  wire [20:0]         rpm_prod = {7'h00, engine_rpm} * {14'h0000, rpm_frequency_factor};
  wire [RPM_ACCW-1:0] rpm_step = {{(RPM_ACCW-21){1'b0}}, rpm_prod};
  rspo_sync u_sync_vss
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (speed_pulse_pin),
    .q       (vss_sync)
  );
  rspo_sync u_sync_fcu
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (control_unit_speed_fault),
    .q       (fault_cu)
  );
  rspo_sync u_sync_fbm
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (body_module_speed_fault),
    .q       (fault_bm)
  );
  assign vss_rise  = vss_sync & ~vss_d;
  assign freq_mode = (switch_speed_threshold == 8'h00);
  assign faulted   = fault_cu | fault_bm;
  assign too_slow  = (vehicle_speed < `RSPO_SLOW_KMH);
  assign trig      = rpm_source ? rpm_tick : vss_rise;
  rspo_pulse_gen #(.CW(CW)) u_pgen
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .trig     (trig),
    .high_cyc (pulse_high_time),
    .pulse    (freq_pulse)
  );
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vss_d    <= 1'b0;
      rpm_acc  <= {RPM_ACCW{1'b0}};
      rpm_tick <= 1'b0;
    end
    else if (ce)
    begin
      vss_d <= vss_sync;
      // the /100 lives in the wrap value, so no divider is needed
      if (rpm_acc + rpm_step >= RPM_WRAP)
      begin
        rpm_acc  <= rpm_acc + rpm_step - RPM_WRAP;
        rpm_tick <= 1'b1;
      end
      else
      begin
        rpm_acc  <= rpm_acc + rpm_step;
        rpm_tick <= 1'b0;
      end
    end
  end
  // switched level with hold at equality
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sw_level <= 1'b0;
    else if (ce)
    begin
      if (vehicle_speed > switch_speed_threshold)
        sw_level <= 1'b1;
      else if (vehicle_speed < switch_speed_threshold)
        sw_level <= 1'b0;
    end
  end
  always @*
  begin
    if (!speed_output_enable)
      next_out = 1'b0;
    else if (faulted)
      next_out = 1'b0;
    else if (freq_mode)
      next_out = too_slow ? 1'b0 : freq_pulse;
    else
      next_out = sw_level ^ switch_invert;
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      road_speed_output <= 1'b0;
    else if (ce)
      road_speed_output <= next_out;
  end
  // bus slave: zero wait, always OKAY
  assign acc_ok = hsel & hready & htrans[1];
  assign wfac = (hwdata[6:0] < `RSPO_FACTOR_MIN) ? `RSPO_FACTOR_MIN :
                (hwdata[6:0] > `RSPO_FACTOR_MAX || hwdata[31:7] != 25'h000_0000) ? `RSPO_FACTOR_MAX :
                hwdata[6:0];
  // out-of-range threshold clamps rather than wrapping into a tiny value
  assign wthr = (hwdata[31:8] != 24'h00_0000 || hwdata[7:0] > `RSPO_THRESH_MAX) ? `RSPO_THRESH_MAX :
                hwdata[7:0];
  always @*
  begin
    case (haddr[7:0])
      `RSPO_CTRL_OFS:     rd_mux = {29'h0000_0000, rpm_source, switch_invert, speed_output_enable};
      `RSPO_THRESH_OFS:   rd_mux = {24'h00_0000, switch_speed_threshold};
      `RSPO_FACTOR_OFS:   rd_mux = {25'h000_0000, rpm_frequency_factor};
      `RSPO_STATUS_OFS:   rd_mux = {28'h000_0000, too_slow, faulted, ~freq_mode, road_speed_output};
      `RSPO_HIGHTIME_OFS: rd_mux = {{(32-CW){1'b0}}, pulse_high_time};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata                 <= 32'h0000_0000;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
      wr_pend                <= 1'b0;
      wr_addr                <= 8'h00;
      speed_output_enable    <= 1'b0;
      switch_invert          <= 1'b0;
      rpm_source             <= 1'b0;
      switch_speed_threshold <= `RSPO_THRESH_RST;
      rpm_frequency_factor   <= `RSPO_FACTOR_RST;
      pulse_high_time        <= HIGH_DEF;
    end
    else if (ce)
    begin
      wr_pend <= acc_ok & hwrite;
      wr_addr <= haddr[7:0];
      if (acc_ok && !hwrite)
        hrdata <= rd_mux;
      if (wr_pend)
      begin
        case (wr_addr)
          `RSPO_CTRL_OFS:
          begin
            speed_output_enable <= hwdata[`RSPO_CTRL_EN_BIT];
            switch_invert       <= hwdata[`RSPO_CTRL_INV_BIT];
            rpm_source          <= hwdata[`RSPO_CTRL_RPM_BIT];
          end
          `RSPO_THRESH_OFS:   switch_speed_threshold <= wthr;
          `RSPO_FACTOR_OFS:   rpm_frequency_factor <= wfac;
          `RSPO_HIGHTIME_OFS: pulse_high_time <= hwdata[CW-1:0];
          default:            ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
